/* File: hw/soc_output_cfg.sv */
/*
 * Output protocol and content registers with lane routing
 * and output frame assembly.
 * Assumes all inputs come from logic on clk; appRst is a
 * synchronous application reset, rst_n the power-on reset.
 */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - GENERAL_OUTPUT_PIN pin follows gp_output_level bit 12
// - Lane config 00: lane1 tri-stated, one lane
// - Lane config 01: lane1 carries alarm
// - Lane config 10: lane1 carries GENERAL_OUTPUT_PIN level
// - Lane config 11: two-lane data output
// - Bit 6 picks external or internal clock
// - Clock select ignored outside master mode
// - Protocol 0x: reuse input SPI mode
// - Protocol 11: converter-mastered timing
// - Reserved protocol register bits read zero
// - Protocol register at bytes 0Ch-0Fh
// - Content register at bytes 10h-13h
// - Bracketed fields clear on power-on only
// - SPI mode code gives polarity, phase
// - Value select picks data or pattern
// - Parity adds two even bits
// - Device id and range inserted on request
module soc_output_cfg (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        appRst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  input  wire logic [1:0]  spiModeSelect,
  input  wire logic        alarmIn,
  input  wire logic        laneData0,
  input  wire logic        laneData1,
  input  wire logic        frameLoad,
  input  wire logic [17:0] convData,
  input  wire logic [3:0]  deviceId,
  input  wire logic [3:0]  rangeCode,
  input  wire logic [1:0]  vddFlags,
  input  wire logic [1:0]  inFlags,
  output logic             generalOutputPin,
  output logic             serialOutLane0,
  output logic             serialOutLane1,
  output logic             serialOutLane1Oe,
  output logic             twoLaneMode,
  output logic             masterMode,
  output logic             ssyncClkInternal,
  output logic             spiCpol,
  output logic             spiCpha,
  output logic      [31:0] frameWord,
  output logic      [5:0]  frameLen
);

  // Fields of output_protocol_ctl
  logic [1:0] protoModeReg;    // Power-on reset only
  logic       ssyncClkReg;     // Power-on reset only
  logic [1:0] laneCfgReg;      // Second lane routing
  logic       gpLevelReg;      // General output level
  // Fields of output_content_ctl
  logic [2:0] valSelReg;       // Data or test pattern
  logic       parEnReg;        // Power-on reset only
  logic       rangeInclReg;    // Append range code
  logic [1:0] inAlmReg;        // Append input flags
  logic [1:0] vddAlmReg;       // Append supply flags
  logic       idInclReg;       // Append device id

  // Address decode
  logic       hitProto;
  logic       hitContent;
  logic [31:0] protoView;      // Register images
  logic [31:0] contentView;
  assign hitProto   = (regAddr == soc_pkg::ADDR_PROTO);
  assign hitContent = (regAddr == soc_pkg::ADDR_CONTENT);

  // Register images, reserved bits tied to zero
  always_comb begin
    protoView = 32'h0;
    protoView[soc_pkg::PROTO_MODE_LSB +: 2] = protoModeReg;
    protoView[soc_pkg::PROTO_SSYNC]          = ssyncClkReg;
    protoView[soc_pkg::PROTO_LANE_LSB +: 2] = laneCfgReg;
    protoView[soc_pkg::PROTO_GPO]            = gpLevelReg;
    contentView = 32'h0;
    contentView[soc_pkg::CONT_VAL_LSB +: 3] = valSelReg;
    contentView[soc_pkg::CONT_PAR]           = parEnReg;
    contentView[soc_pkg::CONT_RANGE]         = rangeInclReg;
    contentView[soc_pkg::CONT_INA_LSB +: 2] = inAlmReg;
    contentView[soc_pkg::CONT_VDA_LSB +: 2] = vddAlmReg;
    contentView[soc_pkg::CONT_ID]            = idInclReg;
  end

  // Power-on-only fields: application reset leaves them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      protoModeReg <= soc_pkg::RST_MODE;
      ssyncClkReg  <= soc_pkg::RST_SSYNC;
      parEnReg     <= soc_pkg::RST_PAR;
    end else begin
      if (regWr && hitProto) begin
        protoModeReg <= regWdata[soc_pkg::PROTO_MODE_LSB +: 2];
        ssyncClkReg  <= regWdata[soc_pkg::PROTO_SSYNC];
      end
      if (regWr && hitContent) begin
        parEnReg <= regWdata[soc_pkg::CONT_PAR];
      end
    end
  end

  // Fields cleared by either reset; app reset beats a write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      laneCfgReg   <= soc_pkg::RST_LANE;
      gpLevelReg   <= soc_pkg::RST_GPO;
      valSelReg    <= soc_pkg::RST_VAL;
      rangeInclReg <= soc_pkg::RST_RANGE;
      inAlmReg     <= soc_pkg::RST_ALM;
      vddAlmReg    <= soc_pkg::RST_ALM;
      idInclReg    <= soc_pkg::RST_ID;
    end else if (appRst) begin
      laneCfgReg   <= soc_pkg::RST_LANE;
      gpLevelReg   <= soc_pkg::RST_GPO;
      valSelReg    <= soc_pkg::RST_VAL;
      rangeInclReg <= soc_pkg::RST_RANGE;
      inAlmReg     <= soc_pkg::RST_ALM;
      vddAlmReg    <= soc_pkg::RST_ALM;
      idInclReg    <= soc_pkg::RST_ID;
    end else begin
      if (regWr && hitProto) begin
        laneCfgReg <= regWdata[soc_pkg::PROTO_LANE_LSB +: 2];
        gpLevelReg <= regWdata[soc_pkg::PROTO_GPO];
      end
      if (regWr && hitContent) begin
        valSelReg    <= regWdata[soc_pkg::CONT_VAL_LSB +: 3];
        rangeInclReg <= regWdata[soc_pkg::CONT_RANGE];
        inAlmReg     <= regWdata[soc_pkg::CONT_INA_LSB +: 2];
        vddAlmReg    <= regWdata[soc_pkg::CONT_VDA_LSB +: 2];
        idInclReg    <= regWdata[soc_pkg::CONT_ID];
      end
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 32'h0;
    end else if (regRd && hitProto) begin
      regRdata <= protoView;
    end else if (regRd && hitContent) begin
      regRdata <= contentView;
    end else begin
      regRdata <= 32'h0; // Unmapped reads and idle give zero
    end
  end

  // Pin routing; lane 1 follows the lane config
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      generalOutputPin <= 1'b0;
      serialOutLane0   <= 1'b0;
      serialOutLane1   <= 1'b0;
      serialOutLane1Oe <= 1'b0;
      twoLaneMode      <= 1'b0;
    end else begin
      generalOutputPin <= gpLevelReg;
      serialOutLane0   <= laneData0;
      twoLaneMode      <= (laneCfgReg == soc_pkg::LANE_DUAL);
      unique case (laneCfgReg)
        soc_pkg::LANE_TRI: begin
          serialOutLane1   <= 1'b0;
          serialOutLane1Oe <= 1'b0;
        end
        soc_pkg::LANE_ALARM: begin
          serialOutLane1   <= alarmIn;
          serialOutLane1Oe <= 1'b1;
        end
        soc_pkg::LANE_GPO: begin
          serialOutLane1   <= gpLevelReg;
          serialOutLane1Oe <= 1'b1;
        end
        soc_pkg::LANE_DUAL: begin
          serialOutLane1   <= laneData1;
          serialOutLane1Oe <= 1'b1;
        end
      endcase
    end
  end

  // Transmit timing; code 10 is never written by the host,
  // so it simply falls into SPI timing here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      masterMode       <= 1'b0;
      ssyncClkInternal <= 1'b0;
      spiCpol          <= 1'b0;
      spiCpha          <= 1'b0;
    end else begin
      masterMode <= (protoModeReg == soc_pkg::MODE_MASTER);
      // Select only honoured in master mode
      ssyncClkInternal <= ssyncClkReg &&
        (protoModeReg == soc_pkg::MODE_MASTER);
      spiCpol <= spiModeSelect[1];
      spiCpha <= spiModeSelect[0];
    end
  end

  // Frame assembly: data, id, flags, range, parity
  logic [17:0] frameData;
  logic [31:0] frameAcc;
  logic [5:0]  frameCnt;
  logic        framePar;
  always_comb begin
    if (!valSelReg[2]) begin
      frameData = convData;
    end else begin
      unique case (valSelReg[1:0])
        soc_pkg::PAT_ZERO: frameData = 18'h0;
        soc_pkg::PAT_ONE:  frameData = 18'h3ffff;
        soc_pkg::PAT_ALT:  frameData = soc_pkg::WORD_ALT;
        default:           frameData = soc_pkg::WORD_PAIR;
      endcase
    end
    frameAcc = {14'h0, frameData};
    frameCnt = soc_pkg::CONV_LEN;
    framePar = 1'b0;
    if (idInclReg) begin
      frameAcc = {frameAcc[27:0], deviceId};
      frameCnt = frameCnt + 6'h4;
    end
    // Alarm flags, low flag ahead of high flag
    if (vddAlmReg[0]) begin
      frameAcc = {frameAcc[30:0], vddFlags[0]};
      frameCnt = frameCnt + 6'h1;
    end
    if (vddAlmReg[1]) begin
      frameAcc = {frameAcc[30:0], vddFlags[1]};
      frameCnt = frameCnt + 6'h1;
    end
    if (inAlmReg[0]) begin
      frameAcc = {frameAcc[30:0], inFlags[0]};
      frameCnt = frameCnt + 6'h1;
    end
    if (inAlmReg[1]) begin
      frameAcc = {frameAcc[30:0], inFlags[1]};
      frameCnt = frameCnt + 6'h1;
    end
    if (rangeInclReg) begin
      frameAcc = {frameAcc[27:0], rangeCode};
      frameCnt = frameCnt + 6'h4;
    end
    if (parEnReg) begin
      // Frame parity excludes the conversion parity bit
      framePar = ^frameAcc;
      frameAcc = {frameAcc[29:0], ^frameData, framePar};
      frameCnt = frameCnt + 6'h2;
    end
  end

  // Frame latched on request, left-justified, MSB first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frameWord <= 32'h0;
      frameLen  <= 6'h0;
    end else if (frameLoad) begin
      frameWord <= frameAcc << (soc_pkg::FRAME_MAX - frameCnt);
      frameLen  <= frameCnt;
    end
  end

  // Checks on the block's outputs and stored fields
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_gpo_pin_level: assert property (
    1'b1 |=> generalOutputPin == $past(gpLevelReg))
    else $error("GENERAL_OUTPUT_PIN pin differs from stored level");
  a_lane_tri_state: assert property (
    laneCfgReg == soc_pkg::LANE_TRI |=> !serialOutLane1Oe)
    else $error("Lane 1 driven while tri-state selected");
  a_lane_alarm_route: assert property (
    laneCfgReg == soc_pkg::LANE_ALARM |=>
      serialOutLane1Oe && serialOutLane1 == $past(alarmIn))
    else $error("Lane 1 not carrying alarm");
  a_lane_gpo_route: assert property (
    laneCfgReg == soc_pkg::LANE_GPO |=>
      serialOutLane1Oe && serialOutLane1 == $past(gpLevelReg) && !twoLaneMode)
    else $error("Lane 1 not carrying GENERAL_OUTPUT_PIN level");
  a_lane_dual_data: assert property (
    laneCfgReg == soc_pkg::LANE_DUAL |=>
      twoLaneMode && serialOutLane1 == $past(laneData1))
    else $error("Two-lane mode not in effect");
  a_ssync_gated_mode: assert property (
    ssyncClkInternal |-> masterMode)
    else $error("Clock select active outside master mode");
  a_spi_mode_copy: assert property (
    1'b1 |=> {spiCpol, spiCpha} == $past(spiModeSelect))
    else $error("SPI polarity or phase wrong");
  a_proto_read_back: assert property (
    regRd && hitProto |=>
      (regRdata & 32'hffffecbc) == 32'h0 &&
      regRdata[9:8] == $past(laneCfgReg))
    else $error("Protocol register read wrong");
  a_content_read_back: assert property (
    regRd && hitContent |=>
      (regRdata & 32'hffff82f0) == 32'h0 &&
      regRdata[2:0] == $past(valSelReg))
    else $error("Content register read wrong");
  a_app_rst_keep: assert property (
    appRst && !regWr |=>
      $stable(protoModeReg) && $stable(parEnReg) &&
      laneCfgReg == soc_pkg::RST_LANE && !gpLevelReg)
    else $error("Application reset handling wrong");
  a_parity_len: assert property (
    frameLoad && parEnReg && !idInclReg && !rangeInclReg &&
      vddAlmReg == 2'h0 && inAlmReg == 2'h0 |=>
      frameLen == 6'h14 && ^frameWord[31:14] == frameWord[13])
    else $error("Parity frame wrong");
  a_pattern_ones: assert property (
    frameLoad && valSelReg == 3'h5 && !parEnReg |=>
      frameWord[31:14] == 18'h3ffff)
    else $error("All-ones pattern wrong");

  c_dual_lane: cover property (
    laneCfgReg == soc_pkg::LANE_DUAL ##1 twoLaneMode);
  c_master_int: cover property (masterMode && ssyncClkInternal);
  c_full_frame: cover property (frameLoad ##1 frameLen == 6'h20);
  c_app_rst: cover property (appRst && parEnReg);

endmodule : soc_output_cfg

`default_nettype wire

/* File: hw/soc_pkg.sv */
/*
 * Constants for the serial output configuration registers.
 * Assumes word-aligned accesses from a plain register port.
 */
package soc_pkg;
  // Byte addresses of the two registers
  localparam logic [7:0] ADDR_PROTO   = 8'h0c;
  localparam logic [7:0] ADDR_CONTENT = 8'h10;
  // Field positions in output_protocol_ctl
  localparam int PROTO_MODE_LSB = 0;
  localparam int PROTO_SSYNC    = 6;
  localparam int PROTO_LANE_LSB = 8;
  localparam int PROTO_GPO      = 12;
  // Field positions in output_content_ctl
  localparam int CONT_VAL_LSB = 0;
  localparam int CONT_PAR     = 3;
  localparam int CONT_RANGE   = 8;
  localparam int CONT_INA_LSB = 10;
  localparam int CONT_VDA_LSB = 12;
  localparam int CONT_ID      = 14;
  // Reset values of all writable fields
  localparam logic [1:0] RST_MODE  = 2'h0;
  localparam logic       RST_SSYNC = 1'b0;
  localparam logic [1:0] RST_LANE  = 2'h0;
  localparam logic       RST_GPO   = 1'b0;
  localparam logic [2:0] RST_VAL   = 3'h0;
  localparam logic       RST_PAR   = 1'b0;
  localparam logic       RST_RANGE = 1'b0;
  localparam logic [1:0] RST_ALM   = 2'h0;
  localparam logic       RST_ID    = 1'b0;
  // Second lane configuration codes
  localparam logic [1:0] LANE_TRI   = 2'h0;
  localparam logic [1:0] LANE_ALARM = 2'h1;
  localparam logic [1:0] LANE_GPO   = 2'h2;
  localparam logic [1:0] LANE_DUAL  = 2'h3;
  // Output protocol code for converter-mastered timing
  localparam logic [1:0] MODE_MASTER = 2'h3;
  // Test patterns, conversion width
  localparam logic [1:0]  PAT_ZERO = 2'h0;
  localparam logic [1:0]  PAT_ONE  = 2'h1;
  localparam logic [1:0]  PAT_ALT  = 2'h2;
  localparam logic [17:0] WORD_ALT  = 18'h15555;
  localparam logic [17:0] WORD_PAIR = 18'h0cccc;
  localparam logic [5:0]  CONV_LEN  = 6'h12;
  localparam logic [5:0]  FRAME_MAX = 6'h20;
endpackage : soc_pkg

/* File: verif/soc_host_model.sv */
/*
 * Host controller model for the register port of soc_output_cfg.
 * Assumes a single clk; callers use the wr and rd tasks.
 */
`timescale 1ns/1ps
`default_nettype none
module soc_host_model (
  input  wire logic        clk,
  output logic      [7:0]  regAddr,
  output logic      [31:0] regWdata,
  output logic             regWr,
  output logic             regRd,
  input  wire logic [31:0] regRdata
);
  // Idle bus at time zero
  initial begin
    regAddr  = 8'h00;
    regWdata = 32'h0000_0000;
    regWr    = 1'b0;
    regRd    = 1'b0;
  end
  // One-cycle write; released lines show inverted data so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    if (a == soc_pkg::ADDR_PROTO && d[1:0] == 2'b10) begin
      d[1:0] = 2'b00; // Invalid protocol code is never sent
    end
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
    regAddr  <= ~a;
    regWdata <= ~d;
  endtask : wr
  // One-cycle read; data taken at the edge after the strobe was sampled
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    regAddr <= ~a;
    @(posedge clk);
    d = regRdata;
  endtask : rd
endmodule : soc_host_model
`default_nettype wire

/* File: verif/tb.sv */
/*
 * Self-checking bench for soc_output_cfg: register map, lane routing,
 * protocol outputs, reset classes and frame assembly.
 * Assumes soc_pkg and soc_host_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        appRst = 1'b0;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, frameWord, rdv;
  logic        regWr, regRd;
  logic [1:0]  spiModeSelect = 2'h0, vddFlags = 2'h0, inFlags = 2'h0;
  logic        alarmIn = 1'b0, laneData0 = 1'b0, laneData1 = 1'b0, frameLoad = 1'b0;
  logic [17:0] convData = 18'h0;
  logic [3:0]  deviceId = 4'h0, rangeCode = 4'h0;
  logic        general_output_pin, lane0, lane1, lane1Oe, twoLane, master, ssyncInt, cpol, cpha;
  logic [5:0]  frameLen;
  logic [31:0] seed = 32'h2ab3; // Fixed seed keeps runs repeatable
  int          miscompares = 0;
  int          compares = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  soc_host_model host (.clk(clk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata));
  soc_output_cfg DUT (.clk(clk), .rst_n(rst_n), .appRst(appRst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .spiModeSelect(spiModeSelect), .alarmIn(alarmIn), .laneData0(laneData0),
    .laneData1(laneData1), .frameLoad(frameLoad), .convData(convData), .deviceId(deviceId),
    .rangeCode(rangeCode), .vddFlags(vddFlags), .inFlags(inFlags), .generalOutputPin(general_output_pin),
    .serialOutLane0(lane0), .serialOutLane1(lane1), .serialOutLane1Oe(lane1Oe),
    .twoLaneMode(twoLane), .masterMode(master), .ssyncClkInternal(ssyncInt),
    .spiCpol(cpol), .spiCpha(cpha), .frameWord(frameWord), .frameLen(frameLen));
  // Xorshift source for stimulus
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // Case-equality compare so unknowns never match
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // Read a register and compare
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    host.rd(a, rdv);
    chk(rdv, exp, "read data");
  endtask : rdChk
  // Verdict and end of run
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  // Reference frame from the content register and sampled sources
  task automatic frameCase(input logic [31:0] cont);
    logic [17:0] cd, v;
    logic [3:0]  id, rg;
    logic [1:0]  vf, nf;
    logic        q[$];
    logic        fp;
    logic [31:0] w;
    host.wr(soc_pkg::ADDR_CONTENT, cont);
    w  = xs();
    cd = w[17:0];
    w  = xs();
    id = w[3:0];
    rg = w[7:4];
    vf = w[9:8];
    nf = w[11:10];
    @(posedge clk);
    convData  <= cd;
    deviceId  <= id;
    rangeCode <= rg;
    vddFlags  <= vf;
    inFlags   <= nf;
    frameLoad <= 1'b1;
    @(posedge clk);
    frameLoad <= 1'b0;
    case (cont[2:0])
      3'b100:  v = 18'h00000;
      3'b101:  v = 18'h3ffff;
      3'b110:  v = soc_pkg::WORD_ALT;
      3'b111:  v = soc_pkg::WORD_PAIR;
      default: v = cd;
    endcase
    for (int i = 17; i >= 0; i--) q.push_back(v[i]);
    if (cont[14]) for (int i = 3; i >= 0; i--) q.push_back(id[i]);
    if (cont[12]) q.push_back(vf[0]);
    if (cont[13]) q.push_back(vf[1]);
    if (cont[10]) q.push_back(nf[0]);
    if (cont[11]) q.push_back(nf[1]);
    if (cont[8]) for (int i = 3; i >= 0; i--) q.push_back(rg[i]);
    if (cont[3]) begin
      fp = 1'b0;
      foreach (q[i]) fp = fp ^ q[i];
      q.push_back(^v);
      q.push_back(fp);
    end
    w = 32'h0000_0000;
    foreach (q[i]) w[31-i] = q[i];
    @(negedge clk);
    chk(frameWord, w, "frame word");
    chk({26'h0, frameLen}, q.size(), "frame length");
  endtask : frameCase
  // Watchdog: run needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end
  // Main sequence
  initial begin
    logic [1:0] m, sm;
    logic       a, l0, l1, gp;
    logic [31:0] r;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdChk(soc_pkg::ADDR_PROTO, 32'h0);
    rdChk(soc_pkg::ADDR_CONTENT, 32'h0);
    chk({general_output_pin, lane1Oe, twoLane, master}, 4'h0, "reset outputs");
    $display("test reset done");
    // Reserved bits and unmapped access
    host.wr(soc_pkg::ADDR_PROTO, 32'hffff_ffff);
    host.wr(soc_pkg::ADDR_CONTENT, 32'hffff_ffff);
    host.wr(8'h14, 32'hffff_ffff);
    rdChk(soc_pkg::ADDR_PROTO, 32'h0000_1343);
    rdChk(soc_pkg::ADDR_CONTENT, 32'h0000_7d0f);
    rdChk(8'h14, 32'h0);
    $display("test map done");
    // Application reset keeps only the power-on class fields
    @(posedge clk);
    appRst <= 1'b1;
    @(posedge clk);
    appRst <= 1'b0;
    rdChk(soc_pkg::ADDR_PROTO, 32'h0000_0043);
    rdChk(soc_pkg::ADDR_CONTENT, 32'h0000_0008);
    $display("test appreset done");
    // Second lane routing, random pin levels
    for (int c = 0; c < 8; c++) begin
      r  = xs();
      gp = r[0];
      host.wr(soc_pkg::ADDR_PROTO, {19'h0, gp, 2'b00, c[1:0], 8'h00});
      a  = r[1];
      l0 = r[2];
      l1 = r[3];
      @(posedge clk);
      alarmIn   <= a;
      laneData0 <= l0;
      laneData1 <= l1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(general_output_pin, gp, "gp pin");
      chk(lane0, l0, "lane0");
      chk(lane1Oe, c[1:0] != 2'b00, "lane1 enable");
      chk(twoLane, c[1:0] == 2'b11, "two lane");
      chk(lane1, c[1:0] == 2'b01 ? a : c[1:0] == 2'b10 ? gp : c[1:0] == 2'b11 ? l1 : 1'b0,
          "lane1 value");
    end
    $display("test lanes done");
    // Protocol select, clock source and SPI mode
    for (int k = 0; k < 8; k++) begin
      host.wr(soc_pkg::ADDR_PROTO, {25'h0, k[2], 4'h0, k[1:0]});
      m  = (k[1:0] == 2'b10) ? 2'b00 : k[1:0];
      r  = xs();
      sm = r[1:0];
      @(posedge clk);
      spiModeSelect <= sm;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(master, m == soc_pkg::MODE_MASTER, "master mode");
      chk(ssyncInt, k[2] && m == soc_pkg::MODE_MASTER, "clock source");
      chk({cpol, cpha}, sm, "spi mode");
    end
    $display("test protocol done");
    // Frame assembly over every value code plus a full-length frame
    for (int k = 0; k < 16; k++) frameCase((xs() & 32'h7d08) | k[2:0]);
    frameCase(32'h0000_0008);
    frameCase(32'h0000_0005);
    frameCase(32'h0000_7d0f);
    $display("test frame done");
    stop_test();
  end
endmodule : tb
`default_nettype wire
